// ===== inc/i2c_thr_pkg.sv
// Package with the register map, field layout and carrier types of the block.
package i2c_thr_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [31:0] RX_THR_ADDR = 32'h5000_1338;
  localparam logic [31:0] TX_THR_ADDR = 32'h5000_133C;
  localparam logic [31:0] CLR_ALL_ADDR = 32'h5000_1340;
  localparam logic [31:0] RECEIVE_UNDERFLOW_CLEAR_BIT_ADDR = 32'h5000_1344;
  localparam logic [31:0] RECEIVE_OVERFLOW_CLEAR_BIT_ADDR = 32'h5000_1348;
  localparam logic [31:0] TRANSMIT_OVERFLOW_CLEAR_BIT_ADDR = 32'h5000_134C;
  localparam logic [31:0] SLAVE_READ_REQUEST_CLEAR_BIT_ADDR = 32'h5000_1350;

  // ****************************************************************
  // Fields, widths and reset values.
  // ****************************************************************
  localparam int THR_W = 5;
  localparam logic [THR_W-1:0] THR_RESET = 5'h00;
  localparam int DATA_W = 32;
  localparam int RAW_W = 6;
  localparam int RX_UNDER_BIT = 0;
  localparam int RX_OVER_BIT = 1;
  localparam int RX_FULL_BIT = 2;
  localparam int TX_OVER_BIT = 3;
  localparam int TX_EMPTY_BIT = 4;
  localparam int RD_REQ_BIT = 5;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int ABORT_W_DEF = 16;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [31:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
  } bus_rsp_type;

  typedef struct packed {
    logic rx_under;
    logic rx_over;
    logic tx_over;
    logic rd_req;
    logic tx_abort;
    logic tx_data_wr;
  } event_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_type;

endpackage

// ===== core/sticky_flag.sv
// Sticky event flag whose set wins over a clear in the same cycle.
`timescale 1ns/1ps
module sticky_flag (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Set and clear strobes.
  input wire logic set_evt,
  input wire logic clr_evt,
  // Flag state.
  output logic flag_q
);

  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clr_evt) begin
      flag_d = 1'b0;
    end
    if (set_evt) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule // sticky_flag

// ===== core/i2c_fifo_threshold_irq_clear.sv
// FIFO thresholds, raw interrupt flags and read-to-clear registers.
//
// Notes on behaviour
// - The receive threshold is 5 bits and its flag rises when the receive level reaches the value plus one.
// - A threshold write whose low 5 bits exceed the buffer depth minus one stores the largest value the depth allows.
// - The transmit threshold is 5 bits and raw bit 4 is high while enabled or active with the level at or below it, the buffer depth minus one meaning the depth.
// - The receive threshold flag sits at raw status bit 2.
// - Reading the combined clear register clears raw bits 0, 1, 3 and 5 and the abort reason, not the clock hold, and pulses the others clear output.
// - Reading the combined clear register leaves the hardware-cleared threshold flags alone.
// - Reading the receive underflow clear register clears raw bit 0.
// - Reading the receive overflow clear register clears raw bit 1.
// - Reading the transmit overflow clear register clears raw bit 3.
// - Reading the slave read request clear register clears raw bit 5.
// - The receive threshold flag drops when the level falls below it or the controller is disabled.
// - The transmit threshold flag drops two cycles after the level rises above the threshold.
// - A read request from a remote master holds the clock line low until software supplies data.
`timescale 1ns/1ps
module i2c_fifo_threshold_irq_clear
  import i2c_thr_pkg::*;
#(
  parameter int FIFO_DEPTH = i2c_thr_pkg::FIFO_DEPTH_DEF,
  parameter int ABORT_W = i2c_thr_pkg::ABORT_W_DEF,
  parameter int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Peripheral register bus.
  input wire i2c_thr_pkg::bus_req_type bus_req,
  output i2c_thr_pkg::bus_rsp_type bus_rsp_q,
  // Controller state and events.
  input wire logic ctrl_enable,
  input wire logic ctrl_active,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] tx_level,
  input wire i2c_thr_pkg::event_type events,
  input wire logic [ABORT_W-1:0] abort_cause,
  input wire logic other_irq_raw,
  // Status toward the controller.
  output logic [i2c_thr_pkg::RAW_W-1:0] raw_interrupt_status_q,
  output logic [ABORT_W-1:0] transmit_abort_reason_q,
  output logic combined_irq_q,
  output logic scl_hold_q,
  output logic others_clear_q,
  output logic [i2c_thr_pkg::THR_W-1:0] receive_level_threshold_q,
  output logic [i2c_thr_pkg::THR_W-1:0] transmit_level_threshold_q
);

  // ****************************************************************
  // Parameter checks.
  // ****************************************************************
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > (1 << THR_W)) begin : g_depth_chk
    $error("FIFO_DEPTH must lie between 1 and 32.");
  end
  if (LVL_W < $clog2(FIFO_DEPTH + 1) || LVL_W > 16) begin : g_lvl_chk
    $error("LVL_W cannot hold the FIFO level.");
  end
  if (ABORT_W < 1 || ABORT_W > DATA_W) begin : g_abort_chk
    $error("ABORT_W must lie between 1 and 32.");
  end

  localparam logic [THR_W-1:0] THR_MAX = THR_W'(FIFO_DEPTH - 1);
  localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
  localparam logic [LVL_W-1:0] LVL_TOP = LVL_W'(FIFO_DEPTH);

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  bus_state_type state_q;
  bus_state_type state_d;
  logic access;
  logic rd_acc;
  logic wr_acc;
  logic hit_rx_thr;
  logic hit_tx_thr;
  logic hit_all;
  logic hit_rx_under;
  logic hit_rx_over;
  logic hit_tx_over;
  logic hit_rd_req;
  logic mapped;
  logic clr_all;
  logic receive_underflow_clear_bit;
  logic receive_overflow_clear_bit;
  logic transmit_overflow_clear_bit;
  logic slave_read_request_clear_bit;

  always_comb begin
    access = (state_q == BUS_IDLE) && bus_req.sel && bus_req.enable;
    rd_acc = access && !bus_req.write;
    wr_acc = access && bus_req.write;
    hit_rx_thr = (bus_req.addr == RX_THR_ADDR);
    hit_tx_thr = (bus_req.addr == TX_THR_ADDR);
    hit_all = (bus_req.addr == CLR_ALL_ADDR);
    hit_rx_under = (bus_req.addr == RECEIVE_UNDERFLOW_CLEAR_BIT_ADDR);
    hit_rx_over = (bus_req.addr == RECEIVE_OVERFLOW_CLEAR_BIT_ADDR);
    hit_tx_over = (bus_req.addr == TRANSMIT_OVERFLOW_CLEAR_BIT_ADDR);
    hit_rd_req = (bus_req.addr == SLAVE_READ_REQUEST_CLEAR_BIT_ADDR);
    mapped = hit_rx_thr | hit_tx_thr | hit_all | hit_rx_under |
             hit_rx_over | hit_tx_over | hit_rd_req;
    // Only reads clear; writes to these addresses are dropped.
    clr_all = rd_acc && hit_all;
    receive_underflow_clear_bit = rd_acc && (hit_rx_under || hit_all);
    receive_overflow_clear_bit = rd_acc && (hit_rx_over || hit_all);
    transmit_overflow_clear_bit = rd_acc && (hit_tx_over || hit_all);
    slave_read_request_clear_bit = rd_acc && (hit_rd_req || hit_all);
  end

  // ****************************************************************
  // Software flags.
  // ****************************************************************
  logic rx_under_flag;
  logic rx_over_flag;
  logic tx_over_flag;
  logic rd_req_flag;

  sticky_flag u_rx_under (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set_evt(events.rx_under),
    .clr_evt(receive_underflow_clear_bit),
    .flag_q(rx_under_flag)
  );

  sticky_flag u_rx_over (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set_evt(events.rx_over),
    .clr_evt(receive_overflow_clear_bit),
    .flag_q(rx_over_flag)
  );

  sticky_flag u_tx_over (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set_evt(events.tx_over),
    .clr_evt(transmit_overflow_clear_bit),
    .flag_q(tx_over_flag)
  );

  sticky_flag u_rd_req (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set_evt(events.rd_req),
    .clr_evt(slave_read_request_clear_bit),
    .flag_q(rd_req_flag)
  );

  // Clock stretch from request until data is written.
  sticky_flag u_scl_hold (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set_evt(events.rd_req),
    .clr_evt(events.tx_data_wr),
    .flag_q(scl_hold_q)
  );

  // ****************************************************************
  // Thresholds, status and response.
  // ****************************************************************
  logic [THR_W-1:0] rx_thr_d;
  logic [THR_W-1:0] tx_thr_d;
  logic [THR_W-1:0] wr_thr;
  logic [LVL_W-1:0] rx_need;
  logic [LVL_W-1:0] tx_allow;
  logic rx_full_q;
  logic rx_full_d;
  logic tx_empty_q;
  logic tx_empty_d;
  logic [ABORT_W-1:0] abort_d;
  logic irq_d;
  logic others_clear_d;
  logic [RAW_W-1:0] raw_now;
  bus_rsp_type rsp_d;

  always_comb begin
    // Writes whose low 5 bits exceed the buffer depth minus one are clamped to that value.
    wr_thr = bus_req.wdata[THR_W-1:0];
    if (wr_thr > THR_MAX) begin
      wr_thr = THR_MAX;
    end
    rx_thr_d = receive_level_threshold_q;
    tx_thr_d = transmit_level_threshold_q;
    if (wr_acc && hit_rx_thr) begin
      rx_thr_d = wr_thr;
    end
    if (wr_acc && hit_tx_thr) begin
      tx_thr_d = wr_thr;
    end
    // Value v asks for v plus one entries.
    rx_need = LVL_W'(receive_level_threshold_q) + LVL_ONE;
    // Value v allows v entries, except the top code allows the depth.
    tx_allow = LVL_W'(transmit_level_threshold_q);
    if (transmit_level_threshold_q == THR_MAX) begin
      tx_allow = LVL_TOP;
    end
    // Hardware-owned: dropped below level or on disable.
    rx_full_d = ctrl_enable && (rx_level >= rx_need);
    // Hardware-owned: dropped once above threshold.
    tx_empty_d = (ctrl_enable || ctrl_active) && (tx_level <= tx_allow);
    raw_now = '0;
    raw_now[RX_UNDER_BIT] = rx_under_flag;
    raw_now[RX_OVER_BIT] = rx_over_flag;
    raw_now[RX_FULL_BIT] = rx_full_q;
    raw_now[TX_OVER_BIT] = tx_over_flag;
    raw_now[TX_EMPTY_BIT] = tx_empty_q;
    raw_now[RD_REQ_BIT] = rd_req_flag;
    // Abort reasons collect until a combined clear; new causes win.
    abort_d = transmit_abort_reason_q;
    if (clr_all) begin
      abort_d = '0;
    end
    if (events.tx_abort) begin
      abort_d = abort_d | abort_cause;
    end
    // Threshold flags stay untouched by the combined clear.
    irq_d = (|raw_now) || other_irq_raw;
    others_clear_d = clr_all;
    state_d = BUS_IDLE;
    rsp_d.rdata = DATA_ZERO;
    rsp_d.ready = 1'b0;
    rsp_d.slverr = 1'b0;
    if (access) begin
      state_d = BUS_DONE;
      rsp_d.ready = 1'b1;
      rsp_d.slverr = !mapped;
    end
    if (rd_acc) begin
      // Bit 0 shows the flag as it was before the clear.
      if (hit_rx_thr) begin
        rsp_d.rdata[THR_W-1:0] = receive_level_threshold_q;
      end
      if (hit_tx_thr) begin
        rsp_d.rdata[THR_W-1:0] = transmit_level_threshold_q;
      end
      if (hit_all) begin
        rsp_d.rdata[0] = combined_irq_q;
      end
      if (hit_rx_under) begin
        rsp_d.rdata[0] = rx_under_flag;
      end
      if (hit_rx_over) begin
        rsp_d.rdata[0] = rx_over_flag;
      end
      if (hit_tx_over) begin
        rsp_d.rdata[0] = tx_over_flag;
      end
      if (hit_rd_req) begin
        rsp_d.rdata[0] = rd_req_flag;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= BUS_IDLE;
      receive_level_threshold_q <= THR_RESET;
      transmit_level_threshold_q <= THR_RESET;
      rx_full_q <= 1'b0;
      tx_empty_q <= 1'b0;
      transmit_abort_reason_q <= '0;
      combined_irq_q <= 1'b0;
      others_clear_q <= 1'b0;
      raw_interrupt_status_q <= '0;
      bus_rsp_q <= '0;
    end else begin
      state_q <= state_d;
      receive_level_threshold_q <= rx_thr_d;
      transmit_level_threshold_q <= tx_thr_d;
      rx_full_q <= rx_full_d;
      tx_empty_q <= tx_empty_d;
      transmit_abort_reason_q <= abort_d;
      combined_irq_q <= irq_d;
      others_clear_q <= others_clear_d;
      raw_interrupt_status_q <= raw_now;
      bus_rsp_q <= rsp_d;
    end
  end

endmodule // i2c_fifo_threshold_irq_clear

// ===== testbench/i2c_thr_sva.sv
// Checker of the threshold and read-to-clear register block.
`timescale 1ns/1ps
module i2c_thr_sva
  import i2c_thr_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int ABORT_W = 16,
  parameter int LVL_W = 6
) (
  // Clock, reset and register bus.
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire i2c_thr_pkg::bus_req_type bus_req,
  input wire i2c_thr_pkg::bus_rsp_type bus_rsp_q,
  // Controller side.
  input wire logic ctrl_enable,
  input wire logic ctrl_active,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] tx_level,
  input wire i2c_thr_pkg::event_type events,
  input wire logic other_irq_raw,
  // Status.
  input wire logic [i2c_thr_pkg::RAW_W-1:0] raw_interrupt_status_q,
  input wire logic [ABORT_W-1:0] transmit_abort_reason_q,
  input wire logic scl_hold_q,
  input wire logic combined_irq_q,
  input wire logic others_clear_q,
  input wire logic [i2c_thr_pkg::THR_W-1:0] receive_level_threshold_q,
  input wire logic [i2c_thr_pkg::THR_W-1:0] transmit_level_threshold_q
);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  logic rd_take;
  logic rx_hit;
  logic tx_hit;
  int tx_lim;
  assign rd_take = bus_req.sel && bus_req.enable && !bus_req.write
    && !bus_rsp_q.ready;
  assign rx_hit = ctrl_enable
    && (int'(rx_level) > int'(receive_level_threshold_q));
  assign tx_lim = (transmit_level_threshold_q == THR_W'(FIFO_DEPTH - 1))
    ? FIFO_DEPTH : int'(transmit_level_threshold_q);
  assign tx_hit = (ctrl_enable || ctrl_active) && (int'(tx_level) <= tx_lim);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_clr(logic [31:0] a, logic e, logic r);
    rd_take && bus_req.addr == a && !e |=> ##1 !r;
  endproperty
  chk_bus_answer: assert property (
    bus_req.sel && bus_req.enable && !bus_rsp_q.ready |=> bus_rsp_q.ready)
    else $error("access not answered");
  chk_ready_once: assert property (bus_rsp_q.ready |=> !bus_rsp_q.ready)
    else $error("ready longer than one cycle");
  chk_receive_underflow_clear_bit: assert property (
    p_clr(RECEIVE_UNDERFLOW_CLEAR_BIT_ADDR, events.rx_under, raw_interrupt_status_q[0]))
    else $error("underflow flag not cleared");
  chk_receive_overflow_clear_bit: assert property (
    p_clr(RECEIVE_OVERFLOW_CLEAR_BIT_ADDR, events.rx_over, raw_interrupt_status_q[1]))
    else $error("overflow flag not cleared");
  chk_transmit_overflow_clear_bit: assert property (
    p_clr(TRANSMIT_OVERFLOW_CLEAR_BIT_ADDR, events.tx_over, raw_interrupt_status_q[3]))
    else $error("transmit overflow flag not cleared");
  chk_slave_read_request_clear_bit: assert property (
    p_clr(SLAVE_READ_REQUEST_CLEAR_BIT_ADDR, events.rd_req, raw_interrupt_status_q[5]))
    else $error("read request flag not cleared");
  chk_clear_all: assert property (
    rd_take && bus_req.addr == CLR_ALL_ADDR && events == '0
    |=> transmit_abort_reason_q == '0 ##1
    (raw_interrupt_status_q & 6'h2B) == 6'h00)
    else $error("combined clear incomplete");
  chk_rx_full_set: assert property (
    rx_hit [*3] |-> raw_interrupt_status_q[2])
    else $error("receive threshold flag missing");
  chk_rx_full_drop: assert property (
    !rx_hit [*3] |-> !raw_interrupt_status_q[2])
    else $error("receive threshold flag stuck");
  chk_tx_empty_on: assert property (
    tx_hit [*3] |-> raw_interrupt_status_q[4])
    else $error("transmit threshold flag wrong");
  chk_tx_empty_off: assert property (
    !tx_hit [*3] |-> !raw_interrupt_status_q[4])
    else $error("transmit threshold flag stuck");
  chk_clear_pulse: assert property (
    rd_take && bus_req.addr == CLR_ALL_ADDR |=> others_clear_q)
    else $error("combined clear pulse missing");
  chk_irq_level: assert property (
    combined_irq_q == ((|raw_interrupt_status_q) || $past(other_irq_raw)))
    else $error("combined interrupt wrong");
  chk_scl_hold_set: assert property (events.rd_req |=> scl_hold_q)
    else $error("clock not held");
  cover property (rx_hit [*3]);
  cover property (bus_rsp_q.ready && bus_rsp_q.slverr);
  cover property (scl_hold_q ##1 !scl_hold_q);
  cover property (others_clear_q);
endmodule // i2c_thr_sva

bind i2c_fifo_threshold_irq_clear i2c_thr_sva #(.FIFO_DEPTH(FIFO_DEPTH),
  .ABORT_W(ABORT_W), .LVL_W(LVL_W)) i2c_thr_sva_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .bus_req(bus_req), .bus_rsp_q(bus_rsp_q),
  .ctrl_enable(ctrl_enable), .ctrl_active(ctrl_active),
  .rx_level(rx_level), .tx_level(tx_level), .events(events),
  .other_irq_raw(other_irq_raw),
  .raw_interrupt_status_q(raw_interrupt_status_q),
  .transmit_abort_reason_q(transmit_abort_reason_q), .scl_hold_q(scl_hold_q),
  .combined_irq_q(combined_irq_q), .others_clear_q(others_clear_q),
  .receive_level_threshold_q(receive_level_threshold_q),
  .transmit_level_threshold_q(transmit_level_threshold_q));

// ===== testbench/testbench.sv
// Self-checking bench of the threshold and read-to-clear register block.
`timescale 1ns/1ps
module testbench;
  import i2c_thr_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  bus_req_type bus_req = '0;
  bus_rsp_type bus_rsp_q;
  logic ctrl_enable = 1'b0;
  logic ctrl_active = 1'b0;
  logic other_irq_raw = 1'b0;
  logic [4:0] rx_level = 5'h00;
  logic [4:0] tx_level = 5'h00;
  event_type events = '0;
  logic [15:0] abort_cause = 16'h0000;
  logic [5:0] raw_q;
  logic [15:0] abort_q;
  logic irq_q;
  logic hold_q;
  logic [4:0] rx_thr_q;
  logic [4:0] tx_thr_q;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  i2c_fifo_threshold_irq_clear #(.FIFO_DEPTH(16))
    i2c_fifo_threshold_irq_clear_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rsp_q(bus_rsp_q), .ctrl_enable(ctrl_enable),
    .ctrl_active(ctrl_active), .rx_level(rx_level), .tx_level(tx_level),
    .events(events), .abort_cause(abort_cause),
    .other_irq_raw(other_irq_raw),
    .raw_interrupt_status_q(raw_q), .transmit_abort_reason_q(abort_q),
    .combined_irq_q(irq_q), .scl_hold_q(hold_q), .others_clear_q(),
    .receive_level_threshold_q(rx_thr_q),
    .transmit_level_threshold_q(tx_thr_q));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    bus_req = '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 bus_req.enable = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (bus_rsp_q.ready !== 1'b1 && n < 8);
    rd = bus_rsp_q.rdata;
    err = bus_rsp_q.slverr;
    #1 bus_req = '0;
    tick(1);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, DATA_ZERO);
    check(rd, e);
  endtask
  task automatic lvl(input logic [4:0] r, input logic [4:0] t,
    input logic [5:0] e);
    rx_level = r;
    tx_level = t;
    tick(3);
    check(raw_q, e);
  endtask
  task automatic pulse(input event_type e);
    events = e;
    tick(1);
    events = '0;
    tick(2);
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic test_thr();
    rchk(RX_THR_ADDR, 32'h0);
    rchk(TX_THR_ADDR, 32'h0);
    bus(1'b1, RX_THR_ADDR, 32'h1F);
    rchk(RX_THR_ADDR, 32'hF);
    bus(1'b1, TX_THR_ADDR, 32'h1F);
    rchk(TX_THR_ADDR, 32'hF);
    ctrl_enable = 1'b1;
    lvl(5'h0F, 5'h10, 6'h10);
    lvl(5'h10, 5'h10, 6'h14);
    lvl(5'h0F, 5'h10, 6'h10);
    lvl(5'h0F, 5'h0F, 6'h10);
    bus(1'b1, RX_THR_ADDR, 32'h0);
    bus(1'b1, TX_THR_ADDR, 32'h2);
    lvl(5'h01, 5'h02, 6'h14);
    lvl(5'h00, 5'h03, 6'h00);
    lvl(5'h01, 5'h10, 6'h04);
    ctrl_enable = 1'b0;
    lvl(5'h01, 5'h10, 6'h00);
    ctrl_active = 1'b1;
    lvl(5'h01, 5'h02, 6'h10);
    ctrl_active = 1'b0;
    ctrl_enable = 1'b1;
    lvl(5'h00, 5'h10, 6'h00);
    $display("test thresholds done");
  endtask
  task automatic test_clear();
    logic [31:0] a[4] = '{RECEIVE_UNDERFLOW_CLEAR_BIT_ADDR, RECEIVE_OVERFLOW_CLEAR_BIT_ADDR,
      TRANSMIT_OVERFLOW_CLEAR_BIT_ADDR, SLAVE_READ_REQUEST_CLEAR_BIT_ADDR};
    int b[4] = '{0, 1, 3, 5};
    for (int i = 0; i < 4; i++) begin
      pulse(event_type'(6'h20 >> i));
      bus(1'b1, a[i], 32'h1);
      check(raw_q, 6'h01 << b[i]);
      rchk(a[i], 32'h1);
      check(raw_q, 6'h00);
      rchk(a[i], 32'h0);
    end
    check(hold_q, 1'b1);
    $display("test single clears done");
  endtask
  task automatic test_all();
    abort_cause = 16'hA5A5;
    lvl(5'h10, 5'h10, 6'h04);
    pulse(event_type'(6'h3E));
    check(raw_q, 6'h2F);
    check(abort_q, 16'hA5A5);
    rchk(CLR_ALL_ADDR, 32'h1);
    check(raw_q, 6'h04);
    check(abort_q, 16'h0000);
    pulse(event_type'(6'h01));
    check(hold_q, 1'b0);
    rchk(32'h5000_1330, 32'h0);
    check(err, 1'b1);
    lvl(5'h00, 5'h10, 6'h00);
    check(irq_q, 1'b0);
    other_irq_raw = 1'b1;
    tick(2);
    check(irq_q, 1'b1);
    other_irq_raw = 1'b0;
    $display("test combined clear done");
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(6);
    sys_rst = 1'b0;
    tick(1);
    test_thr();
    test_clear();
    test_all();
    print_verdict();
  end
endmodule // testbench
